// ### subtract_skip_cfg.svh
// Purpose: constants of the subtract, skip and table read execution unit
// Assumes: one 100 MHz clock, one instruction cycle per clock
// Notes:   register offsets are byte addresses on the plain register port
`ifndef SUBTRACT_SKIP_CFG_SVH
`define SUBTRACT_SKIP_CFG_SVH

// ==========================================================
// register port map
`define REG_ACC_OFS      8'h00
`define REG_STATUS_OFS   8'h01
`define REG_TABLE_POINTER_OFS     8'h02
`define REG_TABLE_HIGH_LATCH_OFS     8'h03
`define REG_MEM_BASE     8'h20

// ==========================================================
// status register fields
`define STATUS_C_BIT     0
`define STATUS_AC_BIT    1
`define STATUS_Z_BIT     2
`define STATUS_OV_BIT    3

// ==========================================================
// reset values and constants
`define ACC_RST          8'h00
`define TABLE_POINTER_RST         8'h00
`define TABLE_HIGH_LATCH_RST         8'h00
`define BYTE_ONES        8'hff
`define BYTE_ONE         8'h01
`define BYTE_ZERO        8'h00

`endif

// ### subtract_skip_pkg.sv
// Purpose: types shared by the execution unit and its users
// Assumes: opcodes arrive already decoded from the fetch stage
// Notes:   only the operations this unit executes are listed
package subtract_skip_pkg;

  // decoded operations handled here
  typedef enum logic [4:0] {
    op_none,
    borrow_minus_into_accumulator,
    borrow_minus_into_memory,
    minus_from_accumulator,
    minus_into_memory,
    minus_immediate,
    decrement_skip_when_zero,
    decrement_to_accumulator_skip,
    increment_skip_when_zero,
    increment_to_accumulator_skip,
    byte_set_all,
    bit_set_one,
    skip_when_bit_set,
    skip_when_bit_clear,
    skip_when_zero,
    copy_skip_when_zero,
    nibble_exchange,
    nibble_exchange_to_accumulator,
    table_read_current_page,
    table_read_last_page
  } op_e;

  // one decoded instruction
  typedef struct packed {
    op_e        op;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] imm;
  } instr_s;

  // arithmetic status flags
  typedef struct packed {
    logic signed_wrap_flag;
    logic zero_flag;
    logic nibble_carry_flag;
    logic carry_flag;
  } flags_s;

endpackage

// ### sub_flag_adder.sv
// Purpose: eight bit a + ~b + cin with the four subtraction flags
// Assumes: cin is one for plain subtraction, carry for borrow forms
// Notes:   purely combinational
`include "subtract_skip_cfg.svh"
`timescale 1ns/10ps
module sub_flag_adder (
  input  wire logic [7:0]                   a,
  input  wire logic [7:0]                   b,
  input  wire logic                         cin,
  output logic [7:0]                        sum,
  output subtract_skip_pkg::flags_s         flags
);
  logic [4:0] low_sum;
  logic [4:0] high_sum;
  logic [7:0] nb;

  // nibble-wise add so the carry out of bit three is visible
  always_comb begin
    nb       = ~b;
    low_sum  = {1'b0, a[3:0]} + {1'b0, nb[3:0]} + {4'b0000, cin};
    high_sum = {1'b0, a[7:4]} + {1'b0, nb[7:4]} + {4'b0000, low_sum[4]};
    sum      = {high_sum[3:0], low_sum[3:0]};
    // carry set means no borrow; signed wrap when like signs give unlike
    flags.carry_flag        = high_sum[4];
    flags.nibble_carry_flag = low_sum[4];
    flags.zero_flag         = (sum == `BYTE_ZERO);
    flags.signed_wrap_flag  = (a[7] == nb[7]) && (sum[7] != a[7]);
  end
endmodule

// ### subtract_skip_table_exec.sv
// Purpose: executes subtract, skip, set, swap and table read instructions
// Assumes: one instruction offered per cycle while ready_q is high
// Notes:   data memory lives here; program memory answers in the read cycle
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`include "subtract_skip_cfg.svh"
`timescale 1ns/10ps
module subtract_skip_table_exec #(
  parameter int MEM_DEPTH = 224,
  parameter int PAGE_BITS = 5
) (
  input  wire logic                         clock,
  input  wire logic                         nrst,
  // decoded instruction from fetch
  input  wire logic                         instr_valid,
  input  wire subtract_skip_pkg::instr_s    instr,
  input  wire logic [PAGE_BITS-1:0]         current_page,
  output logic                              ready_q,
  output logic                              skip_q,
  // program memory for table reads
  output logic                              prog_rd_q,
  output logic [PAGE_BITS+7:0]              prog_addr_q,
  input  wire logic [15:0]                  prog_word,
  // core state seen by the rest of the core
  output logic [7:0]                        acc_q,
  output subtract_skip_pkg::flags_s         flags_q,
  output logic [7:0]                        table_high_latch_q,
  // register port
  input  wire logic [7:0]                   reg_addr,
  input  wire logic [7:0]                   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic [7:0]                        reg_rdata_q
);

  // ==========================================================
  // state and storage
  typedef enum logic [1:0] {
    st_run,
    st_dummy,
    st_table
  } state_e;

  state_e     state_q;
  logic [7:0] mem_q [MEM_DEPTH];
  logic [7:0] table_pointer_q;
  logic [7:0] tbl_dest_q;

  // ==========================================================
  // operand fetch and arithmetic
  logic                       take;
  logic [7:0]                 m_val;
  logic [7:0]                 m_idx;
  logic                       m_hit;
  logic [7:0]                 sub_b;
  logic                       sub_cin;
  logic [7:0]                 sub_sum;
  subtract_skip_pkg::flags_s  sub_flags;
  logic [7:0]                 dec_val;
  logic [7:0]                 inc_val;
  logic [7:0]                 swap_val;
  logic                       bit_val;

  assign take = instr_valid && ready_q;

  // map an instruction address onto the data memory; outside reads zero
  always_comb begin
    m_idx = instr.addr - `REG_MEM_BASE;
    m_hit = (instr.addr >= `REG_MEM_BASE) && (int'(m_idx) < MEM_DEPTH);
    m_val = m_hit ? mem_q[m_idx] : `BYTE_ZERO;
  end

  // one shared subtractor; immediate form swaps the operand source
  always_comb begin
    sub_b   = (instr.op == subtract_skip_pkg::minus_immediate) ? instr.imm : m_val;
    sub_cin = 1'b1;
    if (instr.op == subtract_skip_pkg::borrow_minus_into_memory ||
        instr.op == subtract_skip_pkg::borrow_minus_into_accumulator) begin
      sub_cin = flags_q.carry_flag;
    end
  end

  sub_flag_adder u_sub (
    .a     (acc_q),
    .b     (sub_b),
    .cin   (sub_cin),
    .sum   (sub_sum),
    .flags (sub_flags)
  );

  // plain one-step values; these never touch the flags
  always_comb begin
    dec_val  = m_val - `BYTE_ONE;
    inc_val  = m_val + `BYTE_ONE;
    swap_val = {m_val[3:0], m_val[7:4]};
    bit_val  = m_val[instr.bit_sel];
  end

  // ==========================================================
  // per-operation results
  logic       mem_we;
  logic [7:0] mem_wd;
  logic       acc_we;
  logic [7:0] acc_wd;
  logic       flags_we;
  logic       skip_cond;
  logic       table_op;

  always_comb begin
    mem_we    = 1'b0;
    mem_wd    = m_val;
    acc_we    = 1'b0;
    acc_wd    = acc_q;
    flags_we  = 1'b0;
    skip_cond = 1'b0;
    table_op  = 1'b0;
    case (instr.op)
      subtract_skip_pkg::borrow_minus_into_accumulator,
      subtract_skip_pkg::minus_from_accumulator,
      subtract_skip_pkg::minus_immediate: begin
        acc_we   = 1'b1;
        acc_wd   = sub_sum;
        flags_we = 1'b1;
      end
      subtract_skip_pkg::borrow_minus_into_memory,
      subtract_skip_pkg::minus_into_memory: begin
        mem_we   = 1'b1;
        mem_wd   = sub_sum;
        flags_we = 1'b1;
      end
      subtract_skip_pkg::decrement_skip_when_zero: begin
        mem_we    = 1'b1;
        mem_wd    = dec_val;
        skip_cond = (dec_val == `BYTE_ZERO);
      end
      subtract_skip_pkg::decrement_to_accumulator_skip: begin
        acc_we    = 1'b1;
        acc_wd    = dec_val;
        skip_cond = (dec_val == `BYTE_ZERO);
      end
      subtract_skip_pkg::increment_skip_when_zero: begin
        mem_we    = 1'b1;
        mem_wd    = inc_val;
        skip_cond = (inc_val == `BYTE_ZERO);
      end
      subtract_skip_pkg::increment_to_accumulator_skip: begin
        acc_we    = 1'b1;
        acc_wd    = inc_val;
        skip_cond = (inc_val == `BYTE_ZERO);
      end
      subtract_skip_pkg::byte_set_all: begin
        mem_we = 1'b1;
        mem_wd = `BYTE_ONES;
      end
      subtract_skip_pkg::bit_set_one: begin
        mem_we                 = 1'b1;
        mem_wd[instr.bit_sel]  = 1'b1;
      end
      subtract_skip_pkg::skip_when_bit_set: begin
        skip_cond = bit_val;
      end
      subtract_skip_pkg::skip_when_bit_clear: begin
        skip_cond = !bit_val;
      end
      subtract_skip_pkg::skip_when_zero: begin
        skip_cond = (m_val == `BYTE_ZERO);
      end
      subtract_skip_pkg::copy_skip_when_zero: begin
        acc_we    = 1'b1;
        acc_wd    = m_val;
        skip_cond = (m_val == `BYTE_ZERO);
      end
      subtract_skip_pkg::nibble_exchange: begin
        mem_we = 1'b1;
        mem_wd = swap_val;
      end
      subtract_skip_pkg::nibble_exchange_to_accumulator: begin
        acc_we = 1'b1;
        acc_wd = swap_val;
      end
      subtract_skip_pkg::table_read_current_page,
      subtract_skip_pkg::table_read_last_page: begin
        table_op = 1'b1;
      end
      default: begin
        mem_we = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // sequencing: run, dummy after a skip, program fetch for tables
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= st_run;
    end else begin
      case (state_q)
        st_run: begin
          if (take && table_op) begin
            state_q <= st_table;
          end else if (take && skip_cond) begin
            state_q <= st_dummy;
          end
        end
        st_dummy: begin
          state_q <= st_run;
        end
        st_table: begin
          state_q <= st_run;
        end
        default: begin
          state_q <= st_run;
        end
      endcase
    end
  end

  // ready drops for exactly the one extra cycle; skip tells fetch to flush
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ready_q <= 1'b1;
      skip_q  <= 1'b0;
    end else begin
      skip_q  <= take && skip_cond && !table_op;
      ready_q <= !(take && (skip_cond || table_op));
    end
  end

  // program address: pointer inside current or last page
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prog_rd_q   <= 1'b0;
      prog_addr_q <= '0;
      tbl_dest_q  <= `BYTE_ZERO;
    end else begin
      prog_rd_q <= take && table_op;
      if (take && table_op) begin
        tbl_dest_q <= instr.addr;
        if (instr.op == subtract_skip_pkg::table_read_last_page) begin
          prog_addr_q <= {{PAGE_BITS{1'b1}}, table_pointer_q};
        end else begin
          prog_addr_q <= {current_page, table_pointer_q};
        end
      end
    end
  end

  // ==========================================================
  // accumulator, flags and table latch
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      acc_q <= `ACC_RST;
    end else if (take && acc_we) begin
      acc_q <= acc_wd;
    end else if (reg_wr && reg_addr == `REG_ACC_OFS) begin
      acc_q <= reg_wdata;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      flags_q <= '0;
    end else if (take && flags_we) begin
      flags_q <= sub_flags;
    end else if (reg_wr && reg_addr == `REG_STATUS_OFS) begin
      flags_q.carry_flag        <= reg_wdata[`STATUS_C_BIT];
      flags_q.nibble_carry_flag <= reg_wdata[`STATUS_AC_BIT];
      flags_q.zero_flag         <= reg_wdata[`STATUS_Z_BIT];
      flags_q.signed_wrap_flag  <= reg_wdata[`STATUS_OV_BIT];
    end
  end

  // high byte lands when the program word is on the bus
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      table_high_latch_q <= `TABLE_HIGH_LATCH_RST;
    end else if (state_q == st_table) begin
      table_high_latch_q <= prog_word[15:8];
    end else if (reg_wr && reg_addr == `REG_TABLE_HIGH_LATCH_OFS) begin
      table_high_latch_q <= reg_wdata;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      table_pointer_q <= `TABLE_POINTER_RST;
    end else if (reg_wr && reg_addr == `REG_TABLE_POINTER_OFS) begin
      table_pointer_q <= reg_wdata;
    end
  end

  // ==========================================================
  // data memory: execution and table write win over the register port
  logic [7:0] tbl_idx;
  logic [7:0] bus_idx;
  logic       tbl_hit;
  logic       bus_hit;

  always_comb begin
    tbl_idx = tbl_dest_q - `REG_MEM_BASE;
    bus_idx = reg_addr - `REG_MEM_BASE;
    tbl_hit = (tbl_dest_q >= `REG_MEM_BASE) && (int'(tbl_idx) < MEM_DEPTH);
    bus_hit = (reg_addr >= `REG_MEM_BASE) && (int'(bus_idx) < MEM_DEPTH);
  end

  // no reset: contents are undefined after power-up, as for any ram
  always_ff @(posedge clock) begin
    if (state_q == st_table && tbl_hit) begin
      mem_q[tbl_idx] <= prog_word[7:0];
    end else if (take && mem_we && m_hit) begin
      mem_q[m_idx] <= mem_wd;
    end else if (reg_wr && bus_hit) begin
      mem_q[bus_idx] <= reg_wdata;
    end
  end

  // ==========================================================
  // register port read, one cycle after the strobe
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_q <= `BYTE_ZERO;
    end else if (reg_rd) begin
      reg_rdata_q <= `BYTE_ZERO;
      if (reg_addr == `REG_ACC_OFS) begin
        reg_rdata_q <= acc_q;
      end else if (reg_addr == `REG_STATUS_OFS) begin
        reg_rdata_q <= {4'h0, flags_q.signed_wrap_flag, flags_q.zero_flag,
                        flags_q.nibble_carry_flag, flags_q.carry_flag};
      end else if (reg_addr == `REG_TABLE_POINTER_OFS) begin
        reg_rdata_q <= table_pointer_q;
      end else if (reg_addr == `REG_TABLE_HIGH_LATCH_OFS) begin
        reg_rdata_q <= table_high_latch_q;
      end else if (bus_hit) begin
        reg_rdata_q <= mem_q[bus_idx];
      end
    end else begin
      reg_rdata_q <= `BYTE_ZERO;
    end
  end

endmodule

// ### subtract_skip_props.sv
// Purpose: port level checks of the subtract, skip and table read unit
// Assumes: one clock domain, asynchronous active low reset
// Notes:   memory contents are judged by the bench, not here
`timescale 1ns/10ps
module subtract_skip_props #(
  parameter int MEM_DEPTH = 224,
  parameter int PAGE_BITS = 5
) (
  input wire logic                      clock,
  input wire logic                      nrst,
  input wire logic                      instr_valid,
  input wire subtract_skip_pkg::instr_s instr,
  input wire logic [PAGE_BITS-1:0]      current_page,
  input wire logic                      ready_q,
  input wire logic                      skip_q,
  input wire logic                      prog_rd_q,
  input wire logic [PAGE_BITS+7:0]      prog_addr_q,
  input wire logic [15:0]               prog_word,
  input wire logic [7:0]                acc_q,
  input wire subtract_skip_pkg::flags_s flags_q,
  input wire logic [7:0]                table_high_latch_q,
  input wire logic [7:0]                reg_addr,
  input wire logic [7:0]                reg_wdata,
  input wire logic                      reg_wr,
  input wire logic                      reg_rd,
  input wire logic [7:0]                reg_rdata_q
);
  // ==========
  // helpers: $past needs whole signals, not struct fields
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  logic       take;
  logic [7:0] imm_in;
  logic [7:0] word_high;
  assign take      = instr_valid && ready_q;
  assign imm_in    = instr.imm;
  assign word_high = prog_word[15:8];

  // ==========
  // skip and stall timing, table page and latch, immediate subtraction and untouched flags
  chk_skip_dummy_cycle: assert property (skip_q |-> !ready_q ##1 (ready_q && !skip_q))
    else $error("skip pulse without exactly one dummy cycle");
  chk_ready_low_once: assert property (!ready_q |=> ready_q)
    else $error("unit stalled longer than one cycle");
  chk_table_page_current: assert property (take && instr.op == subtract_skip_pkg::table_read_current_page
    |=> prog_rd_q && !skip_q && prog_addr_q[PAGE_BITS+7:8] == $past(current_page))
    else $error("current page table read went to the wrong page");
  chk_table_page_last: assert property (take && instr.op == subtract_skip_pkg::table_read_last_page
    |=> prog_rd_q && prog_addr_q[PAGE_BITS+7:8] == '1)
    else $error("last page table read went to the wrong page");
  chk_table_high_latch: assert property (prog_rd_q |=> table_high_latch_q == $past(word_high))
    else $error("high byte of the program word not latched");
  chk_imm_result: assert property (take && instr.op == subtract_skip_pkg::minus_immediate
    |=> acc_q == 8'($past(acc_q) - $past(imm_in)))
    else $error("immediate subtraction result wrong");
  chk_imm_no_borrow: assert property (take && instr.op == subtract_skip_pkg::minus_immediate
    |=> flags_q.carry_flag == ($past(acc_q) >= $past(imm_in)))
    else $error("carry does not mean no borrow");
  chk_flags_untouched: assert property (take && !reg_wr && instr.op > subtract_skip_pkg::minus_immediate
    |=> $stable(flags_q))
    else $error("flags changed by a flag free operation");
endmodule

bind subtract_skip_table_exec subtract_skip_props #(.MEM_DEPTH(MEM_DEPTH), .PAGE_BITS(PAGE_BITS)) props (
  .clock, .nrst, .instr_valid, .instr, .current_page, .ready_q, .skip_q, .prog_rd_q, .prog_addr_q,
  .prog_word, .acc_q, .flags_q, .table_high_latch_q, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q);

// ### tb.sv
// Purpose: self checking bench of the subtract, skip and table read unit
// Assumes: data memory at 0x40..0x61 reached the same way by port and opcode
// Notes:   every op_case run presets memory, accumulator and status over the port
`include "subtract_skip_cfg.svh"
`timescale 1ns/10ps
module tb;
  logic                      clock = 1'b0;
  logic                      nrst = 1'b0;
  logic                      instr_valid = 1'b0;
  subtract_skip_pkg::instr_s instr = '0;
  logic [4:0]                current_page = 5'h0a;
  logic                      ready_q, skip_q, prog_rd_q;
  logic [12:0]               prog_addr_q;
  logic [15:0]               prog_word;
  logic [7:0]                acc_q, table_high_latch_q, reg_rdata_q;
  subtract_skip_pkg::flags_s flags_q;
  logic [7:0]                reg_addr = 8'h00;
  logic [7:0]                reg_wdata = 8'h00;
  logic                      reg_wr = 1'b0;
  logic                      reg_rd = 1'b0;
  int                        failures = 0;
  int                        tests_run = 0;
  int                        cycles = 0;

  // ==========
  // clock, program store and unit
  always #5 clock = ~clock;
  function automatic logic [15:0] rom(input logic [12:0] a);
    return {3'h5, a[12:8], a[7:0] ^ 8'ha5};
  endfunction
  // unread program words show the inverse so stale data cannot pass
  assign prog_word = prog_rd_q ? rom(prog_addr_q) : ~rom(prog_addr_q);
  subtract_skip_table_exec #(.MEM_DEPTH(224), .PAGE_BITS(5)) dut (.clock, .nrst, .instr_valid, .instr,
    .current_page, .ready_q, .skip_q, .prog_rd_q, .prog_addr_q, .prog_word, .acc_q, .flags_q,
    .table_high_latch_q, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q);

  // ==========
  // shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_q;
  endtask
  task automatic exec(input subtract_skip_pkg::op_e op, input logic [7:0] a, input logic [2:0] bs,
                      input logic [7:0] imm, output logic sk);
    @(posedge clock);
    instr_valid <= 1'b1;
    instr <= '{op, a, bs, imm};
    @(posedge clock);
    instr_valid <= 1'b0;
    #1 sk = skip_q;
    @(posedge clock);
  endtask
  // one operation from a known state; flags given as {wrap, zero, nibble, carry}
  task automatic op_case(input subtract_skip_pkg::op_e op, input logic [7:0] a0, input logic [3:0] f0,
                         input logic [7:0] m, input int bs, input int imm,
                         input logic [7:0] e_acc, input logic [7:0] e_mem, input logic [3:0] e_fl,
                         input int e_sk);
    logic       sk;
    logic [7:0] v;
    wr(8'h40, m);
    wr(`REG_ACC_OFS, a0);
    wr(`REG_STATUS_OFS, {4'h0, f0});
    exec(op, 8'h40, 3'(bs), 8'(imm), sk);
    rd(8'h40, v);
    check(v, e_mem, "memory");
    check(acc_q, e_acc, "accumulator");
    check({4'h0, flags_q}, {4'h0, e_fl}, "flags");
    check({7'h00, sk}, {7'h00, 1'(e_sk)}, "skip");
  endtask
  // expected {wrap, zero, nibble, carry, sum} of a + ~b + cin
  function automatic logic [11:0] sub8(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, ~b} + 9'(cin);
    h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'(cin);
    return {(a[7] != b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8], s[7:0]};
  endfunction

  // ==========
  // scenarios
  task automatic t_reset;
    logic [7:0] v;
    check({7'h00, ready_q}, 8'h01, "ready after reset");
    for (int i = 0; i < 4; i++) begin
      rd(8'(i), v);
      check(v, 8'h00, "reset value");
    end
    // unmapped place must drop the write and read as zero
    wr(8'h10, 8'h55);
    rd(8'h10, v);
    check(v, 8'h00, "unmapped");
  endtask
  task automatic t_arith;
    logic [11:0] r;
    r = sub8(8'h50, 8'h70, 1'b1);
    op_case(subtract_skip_pkg::minus_from_accumulator, 8'h50, 4'h0, 8'h70, 0, 0, r[7:0], 8'h70, r[11:8], 0);
    r = sub8(8'h80, 8'h01, 1'b1);
    op_case(subtract_skip_pkg::minus_into_memory, 8'h80, 4'h0, 8'h01, 0, 0, 8'h80, r[7:0], r[11:8], 0);
    r = sub8(8'h3a, 8'h3a, 1'b1);
    op_case(subtract_skip_pkg::minus_immediate, 8'h3a, 4'h0, 8'h11, 0, 8'h3a, r[7:0], 8'h11, r[11:8], 0);
    r = sub8(8'h10, 8'h01, 1'b0);
    op_case(subtract_skip_pkg::borrow_minus_into_memory, 8'h10, 4'h0, 8'h01, 0, 0, 8'h10, r[7:0], r[11:8], 0);
    r = sub8(8'h20, 8'h05, 1'b0);
    op_case(subtract_skip_pkg::borrow_minus_into_accumulator, 8'h20, 4'h0, 8'h05, 0, 0,
            r[7:0], 8'h05, r[11:8], 0);
    r = sub8(8'h00, 8'h00, 1'b1);
    op_case(subtract_skip_pkg::borrow_minus_into_memory, 8'h00, 4'h1, 8'h00, 0, 0, 8'h00, r[7:0], r[11:8], 0);
  endtask
  task automatic t_skips;
    op_case(subtract_skip_pkg::decrement_skip_when_zero, 8'h77, 4'h5, 8'h01, 0, 0, 8'h77, 8'h00, 4'h5, 1);
    op_case(subtract_skip_pkg::decrement_skip_when_zero, 8'h77, 4'h5, 8'h00, 0, 0, 8'h77, 8'hff, 4'h5, 0);
    op_case(subtract_skip_pkg::decrement_to_accumulator_skip, 8'h77, 4'h5, 8'h01, 0, 0, 8'h00, 8'h01, 4'h5, 1);
    op_case(subtract_skip_pkg::increment_skip_when_zero, 8'h77, 4'h5, 8'hff, 0, 0, 8'h77, 8'h00, 4'h5, 1);
    op_case(subtract_skip_pkg::increment_to_accumulator_skip, 8'h77, 4'h5, 8'h7f, 0, 0, 8'h80, 8'h7f, 4'h5, 0);
    op_case(subtract_skip_pkg::skip_when_bit_set, 8'h77, 4'h5, 8'h08, 3, 0, 8'h77, 8'h08, 4'h5, 1);
    op_case(subtract_skip_pkg::skip_when_bit_clear, 8'h77, 4'h5, 8'h08, 3, 0, 8'h77, 8'h08, 4'h5, 0);
    op_case(subtract_skip_pkg::skip_when_zero, 8'h77, 4'h5, 8'h00, 0, 0, 8'h77, 8'h00, 4'h5, 1);
    op_case(subtract_skip_pkg::copy_skip_when_zero, 8'h77, 4'h5, 8'h5c, 0, 0, 8'h5c, 8'h5c, 4'h5, 0);
  endtask
  task automatic t_setswap;
    op_case(subtract_skip_pkg::byte_set_all, 8'h77, 4'ha, 8'h12, 0, 0, 8'h77, 8'hff, 4'ha, 0);
    op_case(subtract_skip_pkg::bit_set_one, 8'h77, 4'ha, 8'hf0, 0, 0, 8'h77, 8'hf1, 4'ha, 0);
    op_case(subtract_skip_pkg::nibble_exchange, 8'h77, 4'ha, 8'h3c, 0, 0, 8'h77, 8'hc3, 4'ha, 0);
    op_case(subtract_skip_pkg::nibble_exchange_to_accumulator, 8'h77, 4'ha, 8'h3c, 0, 0, 8'hc3, 8'h3c, 4'ha, 0);
  endtask
  task automatic t_table;
    logic        sk;
    logic [7:0]  v;
    logic [15:0] w;
    // move off the start-up page so a stuck page input cannot pass
    current_page <= 5'h13;
    wr(`REG_TABLE_POINTER_OFS, 8'h9c);
    w = rom({5'h13, 8'h9c});
    exec(subtract_skip_pkg::table_read_current_page, 8'h50, 3'h0, 8'h00, sk);
    rd(8'h50, v);
    check(v, w[7:0], "table low current");
    check(table_high_latch_q, w[15:8], "table high current");
    w = rom({5'h1f, 8'h9c});
    exec(subtract_skip_pkg::table_read_last_page, 8'h51, 3'h0, 8'h00, sk);
    rd(8'h51, v);
    check(v, w[7:0], "table low last");
    check(table_high_latch_q, w[15:8], "table high last");
  endtask
  // an offer during the stall is dropped, then two increments go back to back
  task automatic t_order;
    logic [7:0] v;
    wr(8'h60, 8'h10);
    @(posedge clock);
    instr_valid <= 1'b1;
    instr <= '{subtract_skip_pkg::table_read_current_page, 8'h61, 3'h0, 8'h00};
    @(posedge clock);
    instr <= '{subtract_skip_pkg::increment_skip_when_zero, 8'h60, 3'h0, 8'h00};
    repeat (3) @(posedge clock);
    instr_valid <= 1'b0;
    rd(8'h60, v);
    check(v, 8'h12, "stall and back to back");
  endtask

  // ==========
  // sequence, hang guard and verdict
  task automatic results;
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      $display("[FAIL] %0t run did not finish", $time);
      results;
    end
  end
  initial begin
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    t_reset;
    t_arith;
    t_skips;
    t_setswap;
    t_table;
    t_order;
    results;
  end
endmodule
